// >>> rtl/icr_clear_regs.sv
// Read-to-clear interrupt registers with AHB-Lite slave
// What this block does
// - Reading the transmit-overflow clear register clears raw status bit 3.
// - Reading offset 0x50 clears the read-request flag, raw status bit 5.
// - Reading offset 0x54 clears raw bit 6 and resets the abort cause.
// - Reading offset 0x58 clears the slave-transmit-done flag, raw bit 7.
// - Activity bit stays set while the controller is still active on bus.
// - Register 0x50 reads zero in upper bits and resets to zero.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module icr_clear_regs #(
    parameter int RAW_W   = icr_pkg::RAW_W,
    parameter int CAUSE_W = icr_pkg::CAUSE_W
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic [RAW_W-1:0]   event_set,
    input  wire logic [CAUSE_W-1:0] abort_cause_set,
    input  wire logic               bus_active,
    output logic                    irq
);
    // ========================================
    // Address phase capture
    logic        rd_reg;
    logic        wr_reg;
    logic [7:0]  addr_reg;
    wire         addr_take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_reg   <= 1'b0;
            wr_reg   <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            rd_reg   <= addr_take && !hwrite;
            wr_reg   <= addr_take && hwrite;
            addr_reg <= haddr[7:0];
        end
    end

    // ========================================
    // Decode of the data phase
    wire sel_tx_over = rd_reg && addr_reg == icr_pkg::TX_OVER_CLEAR_OFS;
    wire sel_rd_req  = rd_reg && addr_reg == icr_pkg::READ_REQUEST_CLEAR_OFS;
    wire sel_abort   = rd_reg && addr_reg == icr_pkg::TRANSMIT_ABORT_CLEAR_OFS;
    wire sel_done    = rd_reg && addr_reg == icr_pkg::SLAVE_TX_DONE_CLEAR_OFS;
    wire sel_stop    = rd_reg && addr_reg == icr_pkg::STOP_SEEN_CLEAR_OFS;
    wire wr_mask     = wr_reg && addr_reg == icr_pkg::EVENT_MASK_OFS;
    wire wr_evstat   = wr_reg && addr_reg == icr_pkg::EVENT_STATUS_OFS;

    // ========================================
    // Raw interrupt status
    logic [RAW_W-1:0]   raw_reg;
    logic [RAW_W-1:0]   raw_next;
    logic [RAW_W-1:0]   read_clear;
    logic [CAUSE_W-1:0] cause_reg;
    logic [CAUSE_W-1:0] cause_next;
    always_comb begin
        read_clear = '0;
        read_clear[icr_pkg::TX_OVER_BIT] = sel_tx_over;
        read_clear[icr_pkg::RD_REQ_BIT]  = sel_rd_req;
        read_clear[icr_pkg::TRANSMIT_ABORT_FLAG_BIT] = sel_abort;
        read_clear[icr_pkg::TX_DONE_BIT] = sel_done;
        read_clear[icr_pkg::STOP_BIT]    = sel_stop;
        // writes ignored, set wins over clear
        raw_next = (raw_reg & ~read_clear) | event_set;
        raw_next[icr_pkg::ACTIVITY_BIT] = bus_active | event_set[icr_pkg::ACTIVITY_BIT]
            | (raw_reg[icr_pkg::ACTIVITY_BIT] & ~sel_stop);
        cause_next = (sel_abort ? '0 : cause_reg) | abort_cause_set;
    end

    // ========================================
    // Event status and mask
    logic [RAW_W-1:0] evstat_reg;
    logic [RAW_W-1:0] mask_reg;
    wire  [RAW_W-1:0] w1c = wr_evstat ? hwdata[RAW_W-1:0] : '0;
    wire  [RAW_W-1:0] rise = raw_next & ~raw_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_reg    <= '0;
            cause_reg  <= '0;
            evstat_reg <= '0;
            mask_reg   <= '0;
            irq        <= 1'b0;
        end else begin
            raw_reg    <= raw_next;
            cause_reg  <= cause_next;
            evstat_reg <= (evstat_reg & ~w1c) | rise;
            mask_reg   <= wr_mask ? hwdata[RAW_W-1:0] : mask_reg;
            irq        <= |(((evstat_reg & ~w1c) | rise) & mask_reg);
        end
    end

    // ========================================
    // Read data, registered in the address phase
    logic [31:0] rdata_next;
    wire  [7:0]  ra = haddr[7:0];
    always_comb begin
        rdata_next = icr_pkg::RESET_WORD;
        case (ra)
            icr_pkg::RAW_STATUS_OFS:   rdata_next[RAW_W-1:0]   = raw_reg;
            icr_pkg::ABORT_CAUSE_OFS:  rdata_next[CAUSE_W-1:0] = cause_reg;
            icr_pkg::EVENT_STATUS_OFS: rdata_next[RAW_W-1:0]   = evstat_reg;
            icr_pkg::EVENT_MASK_OFS:   rdata_next[RAW_W-1:0]   = mask_reg;
            default:                   rdata_next = icr_pkg::RESET_WORD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= icr_pkg::RESET_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (addr_take && !hwrite) ? rdata_next : icr_pkg::RESET_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ========================================
    // Checks
    sequence s_abort_read;
        rd_reg && addr_reg == icr_pkg::TRANSMIT_ABORT_CLEAR_OFS;
    endsequence

    a_tx_over_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_tx_over && !event_set[icr_pkg::TX_OVER_BIT] |=> !raw_reg[icr_pkg::TX_OVER_BIT])
        else $error("tx overflow flag not cleared");
    a_rd_req_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_rd_req && !event_set[icr_pkg::RD_REQ_BIT] |=> !raw_reg[icr_pkg::RD_REQ_BIT])
        else $error("read request flag not cleared");
    a_abort_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        s_abort_read ##0 (!event_set[icr_pkg::TRANSMIT_ABORT_FLAG_BIT] && abort_cause_set == '0)
        |=> !raw_reg[icr_pkg::TRANSMIT_ABORT_FLAG_BIT] && cause_reg == '0)
        else $error("abort flag or cause not cleared");
    a_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_done && !event_set[icr_pkg::TX_DONE_BIT] |=> !raw_reg[icr_pkg::TX_DONE_BIT])
        else $error("transmit done flag not cleared");
    a_activity_held: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_active |=> raw_reg[icr_pkg::ACTIVITY_BIT])
        else $error("activity dropped while active");
    a_clear_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_take && !hwrite && haddr[7:0] == icr_pkg::READ_REQUEST_CLEAR_OFS
        |=> hrdata == 32'h0000_0000)
        else $error("clear register read nonzero");
    a_write_no_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_reg && raw_reg[icr_pkg::RD_REQ_BIT] |=> raw_reg[icr_pkg::RD_REQ_BIT])
        else $error("write cleared a flag");
    a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_rd_req && event_set[icr_pkg::RD_REQ_BIT] |=> raw_reg[icr_pkg::RD_REQ_BIT])
        else $error("set lost against clear");
    a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        (evstat_reg & mask_reg) != '0 && !wr_evstat |=> irq)
        else $error("interrupt not raised");

    // ========================================
    // Helpers for the checks
    wire [RAW_W-1:0] hwdata_low = hwdata[RAW_W-1:0];
    wire             rd_take    = addr_take && !hwrite;
    wire [7:0]       rd_ofs     = haddr[7:0];
    wire             clear_ofs  = rd_ofs == icr_pkg::TX_OVER_CLEAR_OFS
                                || rd_ofs == icr_pkg::READ_REQUEST_CLEAR_OFS
                                || rd_ofs == icr_pkg::TRANSMIT_ABORT_CLEAR_OFS
                                || rd_ofs == icr_pkg::SLAVE_TX_DONE_CLEAR_OFS
                                || rd_ofs == icr_pkg::STOP_SEEN_CLEAR_OFS;

    sequence s_no_read_taken;
        !rd_take;
    endsequence

    sequence s_clear_read_taken;
        rd_take && clear_ofs;
    endsequence

    sequence s_raw_read_taken;
        rd_take && rd_ofs == icr_pkg::RAW_STATUS_OFS;
    endsequence

    sequence s_cause_read_taken;
        rd_take && rd_ofs == icr_pkg::ABORT_CAUSE_OFS;
    endsequence

    sequence s_mask_read_taken;
        rd_take && rd_ofs == icr_pkg::EVENT_MASK_OFS;
    endsequence

    // ========================================
    // Bus and register checks
    a_ready_always: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout)
        else $error("wait state inserted");

    a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        !hresp)
        else $error("error response given");

    a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        s_no_read_taken |=> hrdata == icr_pkg::RESET_WORD)
        else $error("read data outside data phase");

    a_clear_regs_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clear_read_taken |=> hrdata == icr_pkg::RESET_WORD)
        else $error("clear register read nonzero");

    a_raw_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        s_raw_read_taken |=> hrdata[RAW_W-1:0] == $past(raw_reg) && hrdata[31:RAW_W] == '0)
        else $error("raw status read wrong");

    a_cause_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cause_read_taken |=> hrdata[CAUSE_W-1:0] == $past(cause_reg))
        else $error("abort cause read wrong");

    a_mask_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        s_mask_read_taken |=> hrdata[RAW_W-1:0] == $past(mask_reg))
        else $error("mask read wrong");

    a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_mask |=> mask_reg == $past(hwdata_low))
        else $error("mask write lost");

    a_evstat_w1c: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_evstat && rise == '0 |=> (evstat_reg & $past(hwdata_low)) == '0)
        else $error("event status not cleared");

    a_evstat_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        rise != '0 |=> (evstat_reg & $past(rise)) == $past(rise))
        else $error("event status missed a rise");

    a_irq_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (evstat_reg & mask_reg) == '0 && rise == '0 |=> !irq)
        else $error("interrupt raised while masked");

    // ========================================
    // Flag and cause checks
    // flags kept without read
    a_raw_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        read_clear == '0 |=> (raw_reg & $past(raw_reg)) == $past(raw_reg))
        else $error("flag lost without clear read");

    a_raw_takes_set: assert property (@(posedge hclk) disable iff (!hresetn)
        event_set != '0 |=> (raw_reg & $past(event_set)) == $past(event_set))
        else $error("event not latched");

    a_cause_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        !sel_abort |=> (cause_reg & $past(cause_reg)) == $past(cause_reg))
        else $error("abort cause lost");

    a_cause_takes_set: assert property (@(posedge hclk) disable iff (!hresetn)
        abort_cause_set != '0 |=> (cause_reg & $past(abort_cause_set)) == $past(abort_cause_set))
        else $error("abort cause not latched");

    a_tx_over_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_tx_over && event_set[icr_pkg::TX_OVER_BIT] |=> raw_reg[icr_pkg::TX_OVER_BIT])
        else $error("overflow set lost");

    a_abort_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_abort && event_set[icr_pkg::TRANSMIT_ABORT_FLAG_BIT] |=> raw_reg[icr_pkg::TRANSMIT_ABORT_FLAG_BIT])
        else $error("abort set lost");

    a_done_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_done && event_set[icr_pkg::TX_DONE_BIT] |=> raw_reg[icr_pkg::TX_DONE_BIT])
        else $error("done set lost");

    a_rd_req_set: assert property (@(posedge hclk) disable iff (!hresetn)
        event_set[icr_pkg::RD_REQ_BIT] |=> raw_reg[icr_pkg::RD_REQ_BIT])
        else $error("read request not latched");

    a_stop_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_stop && !event_set[icr_pkg::STOP_BIT] |=> !raw_reg[icr_pkg::STOP_BIT])
        else $error("stop flag not cleared");

    a_activity_release: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_stop && !bus_active && !event_set[icr_pkg::ACTIVITY_BIT]
        |=> !raw_reg[icr_pkg::ACTIVITY_BIT])
        else $error("activity not released");

    a_activity_set: assert property (@(posedge hclk) disable iff (!hresetn)
        event_set[icr_pkg::ACTIVITY_BIT] |=> raw_reg[icr_pkg::ACTIVITY_BIT])
        else $error("activity event not latched");

endmodule // icr_clear_regs

// >>> shared/icr_pkg.sv
// Register map and field positions of the interrupt clear block
package icr_pkg;
    // ========================================
    // Register offsets
    localparam logic [7:0] TX_OVER_CLEAR_OFS    = 8'h4c;
    localparam logic [7:0] READ_REQUEST_CLEAR_OFS = 8'h50;
    localparam logic [7:0] TRANSMIT_ABORT_CLEAR_OFS = 8'h54;
    localparam logic [7:0] SLAVE_TX_DONE_CLEAR_OFS = 8'h58;
    localparam logic [7:0] STOP_SEEN_CLEAR_OFS  = 8'h60;
    localparam logic [7:0] RAW_STATUS_OFS       = 8'h34;
    localparam logic [7:0] ABORT_CAUSE_OFS      = 8'h80;
    localparam logic [7:0] EVENT_STATUS_OFS     = 8'h90;
    localparam logic [7:0] EVENT_MASK_OFS       = 8'h94;
    // ========================================
    // Raw status bit positions, field widths and bus constants
    localparam int TX_OVER_BIT   = 3;
    localparam int RD_REQ_BIT    = 5;
    localparam int TRANSMIT_ABORT_FLAG_BIT   = 6;
    localparam int TX_DONE_BIT   = 7;
    localparam int ACTIVITY_BIT  = 8;
    localparam int STOP_BIT      = 9;
    localparam int RAW_W         = 12;
    localparam int CAUSE_W       = 16;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HSIZE_WORD = 2'h2;
endpackage

// >>> test/icr_clear_regs_test.sv
// Self-checking testbench for the interrupt clear registers
`timescale 1ns/100ps
module icr_clear_regs_test;
    // ========================================
    // Signals and model state
    logic        hclk, hresetn, hsel, hwrite, bus_active, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, raw_m, cause_m;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] event_set, s;
    logic [15:0] abort_cause_set;
    int          fails, total_checks;
    logic [7:0]  ofs [4] = '{8'h4c, 8'h50, 8'h54, 8'h58};
    int          bitn [4] = '{3, 5, 6, 7};

    icr_clear_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .event_set(event_set), .abort_cause_set(abort_cause_set),
        .bus_active(bus_active), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ========================================
    // Tasks
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fails++;
                print_verdict;
            end
            @(posedge hclk);
        end
    endtask

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
              output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= icr_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_ready;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        r = hrdata;
    endtask

    task pulse(input logic [11:0] e, input logic [15:0] c);
        @(posedge hclk);
        event_set       <= e;
        abort_cause_set <= c;
        @(posedge hclk);
        event_set       <= 12'h0;
        abort_cause_set <= 16'h0;
        raw_m = raw_m | {20'h0, e};
        cause_m = cause_m | {16'h0, c};
    endtask

    task settle;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask

    // ========================================
    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, bus_active} = 4'h0;
        {haddr, hwdata, raw_m, cause_m} = '0;
        {htrans, hsize, event_set, abort_cause_set} = '0;
        fails = 0;
        total_checks = 0;
        void'($urandom(47428));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ofs[i]) begin
            xfer(ofs[i], 1'b0, 32'h0, rd);
            chk("clear reg reset", rd, 32'h0);
        end
        xfer(8'h10, 1'b0, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        $display("reset test done");
        foreach (ofs[i]) begin
            s = (12'($urandom) & 12'h0e8) | (12'h1 << bitn[i]);
            pulse(s, 16'($urandom) | 16'h1);
            xfer(8'h34, 1'b0, 32'h0, rd);
            chk("raw set", rd, raw_m);
            xfer(ofs[i], 1'b1, $urandom, rd);
            xfer(8'h34, 1'b0, 32'h0, rd);
            chk("raw after write", rd, raw_m);
            if (i == 2) begin
                xfer(8'h80, 1'b0, 32'h0, rd);
                chk("abort cause set", rd, cause_m);
                cause_m = 32'h0;
            end
            xfer(ofs[i], 1'b0, 32'h0, rd);
            chk("clear upper bits", rd, 32'h0);
            raw_m[bitn[i]] = 1'b0;
            xfer(8'h34, 1'b0, 32'h0, rd);
            chk("raw cleared", rd, raw_m);
            if (i == 2) begin
                xfer(8'h80, 1'b0, 32'h0, rd);
                chk("abort cause", rd, cause_m);
            end
        end
        $display("clear test done");
        @(posedge hclk);
        bus_active <= 1'b1;
        pulse(12'h100, 16'h0);
        xfer(8'h60, 1'b0, 32'h0, rd);
        xfer(8'h34, 1'b0, 32'h0, rd);
        chk("activity bit", {31'h0, rd[8]}, 32'h1);
        bus_active <= 1'b0;
        $display("activity test done");
        xfer(8'h94, 1'b1, 32'h0, rd);
        xfer(8'h4c, 1'b0, 32'h0, rd);
        xfer(8'h90, 1'b1, 32'hfff, rd);
        pulse(12'h008, 16'h0);
        settle;
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(8'h94, 1'b1, 32'h8, rd);
        settle;
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        xfer(8'h90, 1'b1, 32'h8, rd);
        settle;
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("interrupt test done");
        print_verdict;
    end
endmodule // icr_clear_regs_test
